// ---- ttq_cmd_interp.sv ----
// Overview of operation
// - Time command holds start and stop stamps
// - Stamps used only under absolute-time config
// - Zero date matches time on any day
// - Time query returns both stamps as command
// - Letter plus question mark queries setting
// - Responses wait in output queue until read
// - Response is a command restoring the setting
// - Each response has fixed length and format
// - Many queries per string, answered in order
// - Queries answered at parse, before execute
// - Deferred settings apply only at execute
// - Terminator query returns letter and 0-255
// - Empty read or overflow flags query error
module ttq_cmd_interp #(
    parameter int QDEPTH = 64
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Command byte stream
    input wire logic cmdValid,
    input wire logic [7:0] cmdByte,
    output logic cmdReady,
    // Output queue read side
    input wire logic rdReq,
    output logic [7:0] rdData,
    output logic rdValid,
    // Query error flag
    input wire logic errClr,
    output logic queryError,
    // Internal time-of-day clock
    input wire logic [ttq_pkg::STAMP_W-1:0] nowStamp,
    input wire logic nowTick,
    // Trigger configuration and events
    input wire logic absStartEn,
    input wire logic absStopEn,
    output logic startFire,
    output logic stopFire
);
    import ttq_pkg::*;

    localparam int AW = $clog2(QDEPTH);

    // Whole module state
    typedef struct packed {
        ttq_state_t st;                      // Parser state
        logic [2*STAMP_W-1:0] argSr;         // Digit shift register for time args
        logic [4:0] argCnt;                  // Digits collected so far
        logic argAny;                        // Argument character seen
        logic [9:0] vAcc;                    // Decimal accumulator for terminator
        logic [STAMP_W-1:0] startStamp;      // Active start stamp
        logic [STAMP_W-1:0] stopStamp;       // Active stop stamp
        logic [STAMP_W-1:0] pendStart;       // Waiting for execute
        logic [STAMP_W-1:0] pendStop;        // Waiting for execute
        logic pendP;                         // Time setting pending
        logic [7:0] userTerm;                // Active user terminator
        logic [7:0] pendTerm;                // Pending user terminator
        logic pendV;                         // Terminator setting pending
        logic qKind;                         // Query being emitted: 1 = terminator
        logic [5:0] emitIdx;                 // Response character index
        logic [QDEPTH-1:0][7:0] mem;         // Output queue storage
        logic [AW-1:0] wrPtr;                // Queue write pointer
        logic [AW-1:0] rdPtr;                // Queue read pointer
        logic [AW:0] cnt;                    // Queue fill count
        logic [7:0] rdData;                  // Last byte read out
        logic rdValid;                       // Read data strobe
        logic queryError;                    // Sticky query error
        logic startFire;                     // Start event strobe
        logic stopFire;                      // Stop event strobe
    } ttq_st_t;

    ttq_st_t s_q;
    ttq_st_t s_d;

    // Fold lower case onto upper case letters
    function automatic logic [7:0] toUpper(input logic [7:0] c);
        if (c >= CH_LOWER_A && c <= CH_LOWER_Z) begin
            return c & ~CASE_BIT;
        end
        return c;
    endfunction : toUpper

    // Any upper case letter opens a new command
    function automatic logic isLetter(input logic [7:0] c);
        return (c >= CH_UPPER_A && c <= CH_UPPER_Z);
    endfunction : isLetter

    // Decimal digit test
    function automatic logic isDigit(input logic [7:0] c);
        return (c >= CH_ZERO && c <= CH_NINE);
    endfunction : isDigit

    // One character of HH:MM:SS.T,mm/dd/yy for a stamp
    function automatic logic [7:0] stampChar(input logic [STAMP_W-1:0] s, input logic [5:0] p);
        logic [3:0] di;
        di = 4'd0;
        unique case (p)
            6'd2, 6'd5: return CH_COLON;
            6'd8: return CH_DOT;
            6'd10: return CH_COMMA;
            6'd13, 6'd16: return CH_SLASH;
            6'd0: di = 4'd0;
            6'd1: di = 4'd1;
            6'd3: di = 4'd2;
            6'd4: di = 4'd3;
            6'd6: di = 4'd4;
            6'd7: di = 4'd5;
            6'd9: di = 4'd6;
            6'd11: di = 4'd7;
            6'd12: di = 4'd8;
            6'd14: di = 4'd9;
            6'd15: di = 4'd10;
            6'd17: di = 4'd11;
            6'd18: di = 4'd12;
            // Blank pad keeps each field twenty wide; the parser skips it on replay
            default: return 8'h20;
        endcase
        return CH_ZERO + {4'h0, s[STAMP_W-1-4*di -: 4]};
    endfunction : stampChar

    // Response character for the query being emitted
    function automatic logic [7:0] rspChar(input logic qv, input logic [5:0] idx,
                                           input logic [STAMP_W-1:0] s0, input logic [STAMP_W-1:0] s1,
                                           input logic [7:0] ut);
        if (qv) begin
            // Terminator reply is always three zero-padded digits
            unique case (idx)
                6'd0: return CH_V;
                6'd1: return CH_ZERO + ut / 8'd100;
                6'd2: return CH_ZERO + (ut / 8'd10) % 8'd10;
                default: return CH_ZERO + ut % 8'd10;
            endcase
        end
        if (idx == 6'd0) begin
            return CH_P;
        end
        if (idx == STOP_SEP_POS) begin
            return CH_COMMA;
        end
        if (idx < STOP_SEP_POS) begin
            return stampChar(s0, idx - 6'd1);
        end
        return stampChar(s1, idx - STOP_BASE);
    endfunction : rspChar

    // Stamp compare; an all-zero stamp never fires, a zero date ignores the date
    function automatic logic stampHit(input logic [STAMP_W-1:0] s, input logic [STAMP_W-1:0] n);
        return (s != STAMP_RST)
            && (s[STAMP_W-1:DATE_W] == n[STAMP_W-1:DATE_W])
            && (s[DATE_W-1:0] == '0 || s[DATE_W-1:0] == n[DATE_W-1:0]);
    endfunction : stampHit

    logic [7:0] ub;
    logic inArg;
    logic take;
    logic pop;
    logic push;
    logic room;
    logic [13:0] vNext;

    assign ub = toUpper(cmdByte);
    assign inArg = (s_q.st == ST_PARG) || (s_q.st == ST_VARG);
    // Stall while emitting, and hold back a letter that ends an argument
    assign cmdReady = (s_q.st != ST_EMIT) && !(inArg && isLetter(ub));
    assign take = cmdValid && cmdReady;
    assign pop = rdReq && (s_q.cnt != '0);
    assign push = (s_q.st == ST_EMIT);
    assign room = (s_q.cnt != (AW+1)'(QDEPTH)) || pop;
    assign vNext = 14'(s_q.vAcc) * 14'd10 + 14'(ub - CH_ZERO);

    // Next-state logic for parser, queue and triggers
    always_comb begin
        s_d = s_q;
        s_d.rdValid = 1'b0;
        // Parser
        unique case (s_q.st)
            ST_IDLE: begin
                if (take) begin
                    s_d.argSr = '0;
                    s_d.argCnt = 5'd0;
                    s_d.argAny = 1'b0;
                    s_d.vAcc = 10'd0;
                    if (ub == CH_P) begin
                        s_d.st = ST_PARG;
                    end else if (ub == CH_V) begin
                        s_d.st = ST_VARG;
                    end else if (ub == CH_X) begin
                        // Execute: deferred settings land now
                        if (s_q.pendP) begin
                            s_d.startStamp = s_q.pendStart;
                            s_d.stopStamp = s_q.pendStop;
                            s_d.pendP = 1'b0;
                        end
                        if (s_q.pendV) begin
                            s_d.userTerm = s_q.pendTerm;
                            s_d.pendV = 1'b0;
                        end
                    end
                    // Other letters belong to other command handlers
                end
            end
            ST_PARG, ST_VARG: begin
                if (cmdValid && isLetter(ub)) begin
                    // Next command ends the argument; letter stays on the input
                    s_d.st = ST_IDLE;
                    if (s_q.st == ST_PARG && s_q.argCnt == ARG_DIGITS) begin
                        s_d.pendStart = s_q.argSr[2*STAMP_W-1:STAMP_W];
                        s_d.pendStop = s_q.argSr[STAMP_W-1:0];
                        s_d.pendP = 1'b1;
                    end
                    if (s_q.st == ST_VARG && s_q.argAny && s_q.vAcc <= USER_TERM_MAX) begin
                        s_d.pendTerm = s_q.vAcc[7:0];
                        s_d.pendV = 1'b1;
                    end
                end else if (take && ub == CH_QMARK && !s_q.argAny) begin
                    // Query right after the letter: answer now
                    s_d.st = ST_EMIT;
                    s_d.qKind = (s_q.st == ST_VARG);
                    s_d.emitIdx = 6'd0;
                end else if (take && isDigit(ub)) begin
                    s_d.argAny = 1'b1;
                    if (s_q.argCnt != ARG_DIGITS) begin
                        s_d.argSr = {s_q.argSr[2*STAMP_W-5:0], ub[3:0]};
                        s_d.argCnt = s_q.argCnt + 5'd1;
                    end
                    // Saturate so an out-of-range value is never applied
                    s_d.vAcc = (vNext > 14'(USER_TERM_MAX)) ? USER_TERM_BAD : vNext[9:0];
                end else if (take) begin
                    // Separators only mark that arguments began; blanks leave argAny unchanged
                    s_d.argAny = s_q.argAny || (ub != 8'h20);
                end
            end
            ST_EMIT: begin
                // One response byte per cycle, fixed length per query
                if ((s_q.qKind && s_q.emitIdx == V_RSP_LEN - 6'd1)
                    || (!s_q.qKind && s_q.emitIdx == P_RSP_LEN - 6'd1)) begin
                    s_d.st = ST_IDLE;
                end
                s_d.emitIdx = s_q.emitIdx + 6'd1;
            end
            default: s_d.st = ST_IDLE;
        endcase
        // Output queue; reads and writes may share a cycle
        if (errClr) begin
            s_d.queryError = 1'b0;
        end
        if (pop) begin
            s_d.rdData = s_q.mem[s_q.rdPtr];
            s_d.rdPtr = s_q.rdPtr + AW'(1);
            s_d.rdValid = 1'b1;
        end else if (rdReq) begin
            s_d.queryError = 1'b1;
        end
        if (push && room) begin
            s_d.mem[s_q.wrPtr] = rspChar(s_q.qKind, s_q.emitIdx, s_q.startStamp,
                                         s_q.stopStamp, s_q.userTerm);
            s_d.wrPtr = s_q.wrPtr + AW'(1);
        end else if (push) begin
            // Full: byte is lost and software is told
            s_d.queryError = 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push && room) - (AW+1)'(pop);
        // Absolute-time events on each tenth-second tick
        s_d.startFire = nowTick && absStartEn && stampHit(s_q.startStamp, nowStamp);
        s_d.stopFire = nowTick && absStopEn && stampHit(s_q.stopStamp, nowStamp);
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.startStamp <= STAMP_RST;
            s_q.stopStamp <= STAMP_RST;
            s_q.userTerm <= USER_TERM_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign rdData = s_q.rdData;
    assign rdValid = s_q.rdValid;
    assign queryError = s_q.queryError;
    assign startFire = s_q.startFire;
    assign stopFire = s_q.stopFire;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Empty read raises the error flag
    empty_read_err_a: assert property (
        rdReq && s_q.cnt == '0 && !errClr |=> queryError
    ) else $error("empty read did not flag query error");

    // A read of a non-empty queue returns a byte next cycle
    queue_read_a: assert property (
        rdReq && s_q.cnt != '0 |=> rdValid && rdData == $past(s_q.mem[s_q.rdPtr])
    ) else $error("queued byte not delivered");

    // Parser stalls while a response is produced
    emit_stall_a: assert property (
        s_q.st == ST_EMIT |-> !cmdReady
    ) else $error("command accepted during response");

    // Terminator reply is four bytes long
    vrsp_length_a: assert property (
        s_q.st == ST_EMIT && $past(s_q.st) != ST_EMIT && s_q.qKind
        |-> (s_q.st == ST_EMIT) [*4] ##1 s_q.st == ST_IDLE
    ) else $error("terminator response length wrong");

    // Time reply is forty-two bytes long
    prsp_length_a: assert property (
        s_q.st == ST_EMIT && $past(s_q.st) != ST_EMIT && !s_q.qKind
        |-> ##41 s_q.st == ST_EMIT ##1 s_q.st == ST_IDLE
    ) else $error("time response length wrong");

    // Execute applies a pending terminator
    deferred_apply_a: assert property (
        take && s_q.st == ST_IDLE && ub == CH_X && s_q.pendV
        |=> s_q.userTerm == $past(s_q.pendTerm) && !s_q.pendV
    ) else $error("deferred setting not applied on execute");

    // Active settings only change at execute
    hold_until_exec_a: assert property (
        !(take && s_q.st == ST_IDLE && ub == CH_X) |=> $stable(s_q.userTerm) && $stable(s_q.startStamp)
    ) else $error("setting changed without execute");

    // A matching stamp fires start on the next edge
    start_fire_a: assert property (
        nowTick && absStartEn && stampHit(s_q.startStamp, nowStamp) |=> startFire
    ) else $error("start stamp match missed");

    // Stop event only under absolute-time configuration and a nonzero stamp
    fire_gate_a: assert property (
        stopFire |-> $past(absStopEn) && $past(s_q.stopStamp) != STAMP_RST && $past(nowTick)
    ) else $error("stop fired without absolute-time config");

    // First reply byte is the command letter
    rsp_letter_a: assert property (
        push && room && s_q.emitIdx == 6'd0
        |=> s_q.mem[$past(s_q.wrPtr)] == ($past(s_q.qKind) ? CH_V : CH_P)
    ) else $error("response does not start with command letter");

endmodule : ttq_cmd_interp

// ---- ttq_cmd_interp_tb_top.sv ----
module ttq_cmd_interp_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ttq_pkg::*;

    // Expected response: kind 1 is the time query, 2 the terminator query
    typedef struct {int k; logic [51:0] s0; logic [51:0] s1; int v;} ttq_rsp_t;
    localparam int QD = 64; // Queue depth; 16 terminator replies fill it exactly
    // Design connections
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmdValid, cmdReady, rdReq, rdValid, queryError, startFire, stopFire;
    logic [7:0] cmdByte, rdData;
    logic errClr = 1'b0;
    logic nowTick = 1'b0;
    logic absStartEn = 1'b0;
    logic absStopEn = 1'b0;
    logic [STAMP_W-1:0] nowStamp = STAMP_RST;
    // Reference model: committed and pending settings, queued replies
    logic [STAMP_W-1:0] mS0, mS1, pS0, pS1, sA, sB, sC;
    int mV, pV, qBytes;
    bit pPv, pVv, expErr;
    ttq_rsp_t rq[$];
    string lastP, s;
    logic [31:0] lfsrQ = 32'h6EF284F0;
    int failCount = 0;
    int checksDone = 0;

    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    ttq_cmd_interp #(.QDEPTH(QD)) uut (.core_clk(core_clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .cmdReady(cmdReady), .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid),
        .errClr(errClr), .queryError(queryError), .nowStamp(nowStamp), .nowTick(nowTick),
        .absStartEn(absStartEn), .absStopEn(absStopEn), .startFire(startFire), .stopFire(stopFire));

    ttq_host_model host (.core_clk(core_clk), .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdReady(cmdReady),
        .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid));

    // Pseudo-random source with a fixed seed
    function automatic logic [31:0] rnd();
        lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
        return lfsrQ;
    endfunction : rnd

    // Random BCD stamp; nonzero hour so it stays live, date zero when undated
    function automatic logic [STAMP_W-1:0] rndStamp(input bit dated);
        logic [STAMP_W-1:0] t = '0;
        for (int i = 0; i < STAMP_DIGITS; i++) t = {t[STAMP_W-5:0], 4'(rnd() % 10)};
        t[48] = 1'b1;
        if (dated) t[16] = 1'b1;
        else t[DATE_W-1:0] = '0;
        return t;
    endfunction : rndStamp

    // Stamp as command text HH:MM:SS.T,mm/dd/yy
    function automatic string fmt(input logic [STAMP_W-1:0] t);
        string r = "";
        for (int i = 0; i < STAMP_DIGITS; i++) begin
            r = $sformatf("%s%0d", r, t[STAMP_W-1-4*i -: 4]);
            case (i)
                1, 3: r = {r, ":"};
                5: r = {r, "."};
                6: r = {r, ","};
                8, 10: r = {r, "/"};
                default: ;
            endcase
        end
        return r;
    endfunction : fmt

    // Digits of one 20-character reply field, separators skipped
    function automatic logic [STAMP_W-1:0] digs(input logic [7:0] b [42], input int base);
        logic [STAMP_W-1:0] t = '0;
        for (int i = base; i < base + 20; i++) if (b[i] >= CH_ZERO && b[i] <= CH_NINE) t = {t[STAMP_W-5:0], b[i][3:0]};
        return t;
    endfunction : digs

    // Absolute-time match: live stamp, same time, date zero or equal
    function automatic bit hit(input logic [STAMP_W-1:0] t, input logic [STAMP_W-1:0] n);
        return t != 0 && t[51:24] == n[51:24] && (t[23:0] == 0 || t[23:0] == n[23:0]);
    endfunction : hit

    // Compare and count
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic testDone();
        if (failCount == 0 && checksDone > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : testDone

    // Reset for 3 cycles and clear the model
    task automatic resetDut();
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        {mS0, mS1, mV, pPv, pVv, qBytes, expErr} = '0;
        rq.delete();
        @(negedge core_clk);
        chk({cmdReady, rdValid, queryError, startFire, stopFire}, 5'b10000);
    endtask : resetDut

    // Model the string, then send it; replies queue at parse time
    task automatic cmd(input string str);
        int mode = 0;
        int nd = 0;
        int val = 0;
        bit any = 0;
        logic [103:0] acc = '0;
        byte c;
        for (int i = 0; i < str.len(); i++) begin
            c = str[i];
            if (c == "?" && mode != 0 && !any) begin
                // Full reply only if it fits, otherwise flagged as lost
                if (qBytes + (mode == 1 ? 42 : 4) > QD) expErr = 1;
                else rq.push_back('{mode, mS0, mS1, mV});
                if (qBytes + (mode == 1 ? 42 : 4) <= QD) qBytes += (mode == 1) ? 42 : 4;
                mode = 0;
            end else if (c >= "A" && c <= "Z") begin
                if (mode == 1 && nd == 26) {pS0, pS1, pPv} = {acc, 1'b1};
                if (mode == 2 && any && val <= 255) {pV, pVv} = {val, 1'b1};
                if (c == "X" && pPv) {mS0, mS1} = {pS0, pS1};
                if (c == "X" && pVv) mV = pV;
                if (c == "X") {pPv, pVv} = 2'b00;
                mode = (c == "P") ? 1 : (c == "V") ? 2 : 0;
                {nd, val, any} = '0;
            end else if (c >= "0" && c <= "9") begin
                any = 1;
                nd++;
                acc = {acc[99:0], 4'(c - "0")};
                if (val < 1000) val = val * 10 + c - "0";
            end else if (c != " ") any = 1;
        end
        host.sendStr(str);
    endtask : cmd

    // Read all queued replies, then one read too many
    task automatic drain();
        logic [7:0] b [42];
        logic v;
        int n;
        while (rq.size() > 0) begin
            n = (rq[0].k == 1) ? P_RSP_LEN : V_RSP_LEN;
            for (int k = 0; k < n; k++) begin
                host.readByte(b[k], v);
                chk(v, 1'b1);
            end
            if (n == P_RSP_LEN) begin
                lastP = "";
                for (int k = 0; k < n; k++) lastP = $sformatf("%s%c", lastP, b[k]);
                chk({b[0], b[STOP_SEP_POS]}, {CH_P, CH_COMMA});
                chk(digs(b, 1), rq[0].s0);
                chk(digs(b, STOP_BASE), rq[0].s1);
            end else begin
                chk({b[0], b[1], b[2], b[3]}, {CH_V, 8'(CH_ZERO + rq[0].v / 100),
                    8'(CH_ZERO + rq[0].v / 10 % 10), 8'(CH_ZERO + rq[0].v % 10)});
            end
            qBytes -= n;
            rq.delete(0);
        end
        chk(queryError, expErr);
        host.readByte(b[0], v);
        chk({v, queryError}, 2'b01);
        @(posedge core_clk);
        errClr <= 1'b1;
        @(posedge core_clk);
        errClr <= 1'b0;
        @(negedge core_clk);
        chk(queryError, 1'b0);
        expErr = 0;
    endtask : drain

    // One clock tick of the internal time, then look at both events
    task automatic trig(input logic [STAMP_W-1:0] now, input bit tk, input bit sEn, input bit pEn);
        @(posedge core_clk);
        nowStamp <= now;
        nowTick <= tk;
        absStartEn <= sEn;
        absStopEn <= pEn;
        @(posedge core_clk);
        nowTick <= 1'b0;
        @(negedge core_clk);
        chk(startFire, tk && sEn && hit(mS0, now));
        chk(stopFire, tk && pEn && hit(mS1, now));
    endtask : trig

    // Main sequence
    initial begin
        resetDut();
        cmd("P?V?X");
        drain();
        sA = rndStamp(1);
        sB = rndStamp(0);
        cmd($sformatf("P%s,%sV%0dP?V?X", fmt(sA), fmt(sB), rnd() % 256));
        drain();
        cmd("P? V?X");
        drain();
        cmd("V255XV?XV256XV?X");
        drain();
        cmd("P?X");
        drain();
        cmd($sformatf("P%s,%sX", fmt(rndStamp(1)), fmt(rndStamp(1))));
        cmd({lastP, "X"});
        cmd("P?X");
        drain();
        s = "";
        repeat (17) s = {s, "V?"};
        cmd({s, "X"});
        drain();
        cmd("V7X");
        @(posedge core_clk);
        resetDut();
        cmd("V?P?X");
        drain();
        sC = rndStamp(1);
        cmd($sformatf("P%s,%sX", fmt(sA), fmt(sB)));
        trig(sA, 1, 0, 1);
        trig(sA, 0, 1, 1);
        trig(sA, 1, 1, 0);
        trig(sA ^ (52'h1 << 24), 1, 1, 1);
        trig({sB[51:24], sC[23:0]}, 1, 1, 1);
        cmd($sformatf("P%s,%sX", fmt(52'h0), fmt(sB)));
        trig(52'h0, 1, 1, 1);
        trig({sB[51:24], sC[23:0]}, 1, 1, 1);
        testDone();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (30000) @(posedge core_clk);
        failCount++;
        testDone();
    end

endmodule : ttq_cmd_interp_tb_top

// ---- ttq_host_model.sv ----
module ttq_host_model (
    // Clock
    input wire logic core_clk,
    // Command byte stream
    output logic cmdValid,
    output logic [7:0] cmdByte,
    input wire logic cmdReady,
    // Output queue read side
    output logic rdReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus released at time zero
    initial begin
        cmdValid = 1'b0;
        cmdByte = 8'hA5;
        rdReq = 1'b0;
    end

    // Send a string byte by byte, holding each byte until the edge that takes it
    task automatic sendStr(input string s);
        int n;
        logic ok;
        @(posedge core_clk);
        for (int k = 0; k < s.len(); k++) begin
            cmdValid <= 1'b1;
            cmdByte <= s[k];
            ok = 1'b0;
            // Ready seen at the falling edge holds until the rising edge
            for (n = 0; n < 200 && !ok; n++) begin
                @(negedge core_clk);
                ok = cmdReady;
                @(posedge core_clk);
            end
        end
        // Released byte lane shows the inverse, so a stale byte never looks valid
        cmdValid <= 1'b0;
        cmdByte <= ~s[s.len()-1];
    endtask : sendStr

    // One-cycle read request, answer sampled in the following cycle
    task automatic readByte(output logic [7:0] b, output logic v);
        @(posedge core_clk);
        rdReq <= 1'b1;
        @(posedge core_clk);
        rdReq <= 1'b0;
        @(negedge core_clk);
        v = rdValid;
        b = rdData;
    endtask : readByte

endmodule : ttq_host_model

// ---- ttq_pkg.sv ----
package ttq_pkg;

    // Character codes seen by the parser and used in responses
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_V = 8'h56;
    localparam logic [7:0] CH_X = 8'h58;
    localparam logic [7:0] CH_QMARK = 8'h3F;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_SLASH = 8'h2F;
    localparam logic [7:0] CH_UPPER_A = 8'h41;
    localparam logic [7:0] CH_UPPER_Z = 8'h5A;
    localparam logic [7:0] CH_LOWER_A = 8'h61;
    localparam logic [7:0] CH_LOWER_Z = 8'h7A;
    localparam logic [7:0] CASE_BIT = 8'h20;

    // Stamp layout: 13 BCD digits HHMMSST mmddyy, first digit in the top nibble
    localparam int STAMP_DIGITS = 13;
    localparam int STAMP_W = 52;
    localparam int DATE_W = 24;
    localparam logic [4:0] ARG_DIGITS = 5'd26;
    localparam logic [STAMP_W-1:0] STAMP_RST = 52'h0;

    // Response lengths and positions
    localparam logic [5:0] P_RSP_LEN = 6'd42;
    localparam logic [5:0] V_RSP_LEN = 6'd4;
    localparam logic [5:0] STOP_SEP_POS = 6'd21;
    localparam logic [5:0] STOP_BASE = 6'd22;

    // User terminator value
    localparam logic [7:0] USER_TERM_RST = 8'h00;
    localparam logic [9:0] USER_TERM_MAX = 10'd255;
    localparam logic [9:0] USER_TERM_BAD = 10'd256;

    // Parser states; one-bit steps for idle -> PARG -> idle and VARG -> emit -> idle, both bits flip for idle -> VARG -> idle and PARG -> emit
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PARG = 2'b01,
        ST_VARG = 2'b11,
        ST_EMIT = 2'b10
    } ttq_state_t;

endpackage : ttq_pkg
